// *** hw/ubc_config.sv ***
/*
 ubc_config: baud divisor and frame configuration registers of the
 async serial interface, pin routing and the oversampling tick.
 assumes: Avalon-MM master on clk; pins arrive unsynchronised;
 tx/rx sequencers run on the same clock and use tick.
*/
// The Avalon-MM register port and the register offsets were left to the implementer.
// Functional notes
// - all serial activity halts while the chip is in any stop mode.
// - high divisor write is buffered; low write loads the full divisor.
// - low byte resets non-zero; generator idle until tx or rx enabled.
// - divisor zero disables the rate generator, no ticks.
// - divisor is thirteen bits; low byte bits 7:0, high byte the rest.
// - loop select feeds transmitter into receiver, except single-wire with direction clear; receive pin unused.
// - receiver source matters only in loop; zero loopback, one single-wire.
// - wait freeze stops clocks in wait mode; cleared keeps them running.
// - character length bit adds ninth data bit before stop.
// - wakeup bit selects idle-line or address-mark wakeup.
// - idle type picks count start after start or stop bit.
// - parity enable generates and checks parity in the top data bit.
// - parity type selects even or odd count of ones.
// - receive pin released when receiver off or loop select set.
// - single-wire direction bit decides if transmit pin drives.
`timescale 1ns/1ps
module ubc_config import ubc_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic stopMode,
	input wire logic waitMode,
	input wire logic rxPinIn,
	output logic rxPinOwned,
	input wire logic txPinIn,
	output logic txPinOut,
	output logic txPinOe,
	input wire logic txSerial,
	input wire logic txBusy,
	output logic rxSerial,
	output logic baudTick,
	output logic transmitterEnable,
	output logic receiverEnable,
	output logic nineBitChars,
	output logic addressMarkWake,
	output logic idleAfterStop,
	output logic [3:0] frameBits,
	output logic [3:0] idleBits,
	input wire logic [8:0] txChar,
	output logic txParityBit,
	input wire logic [8:0] rxChar,
	output logic rxParityError
);
	ubc_bus_t bus_reg;
	ubc_bus_t bus_next;
	ubc_route_t route;
	logic [4:0] highBuf_reg;
	logic [DIV_W-1:0] divisor_reg;
	logic [7:0] frameOne_reg;
	logic txEnable_reg;
	logic rxEnable_reg;
	logic wireDir_reg;
	logic armed_reg;
	logic [31:0] readdata_reg;
	logic [31:0] readNext;
	logic [1:0] pinMeta_reg;
	logic [1:0] pinSync_reg;
	logic [1:0] pinRaw;
	logic request;
	logic accept;
	logic doWrite;
	logic lowLane;
	logic wrHigh;
	logic wrLow;
	logic wrFrameOne;
	logic wrFrameTwo;
	logic wrLine;
	logic loopSel;
	logic rxSource;
	logic waitFreeze;
	logic genEnable;
	logic genHold;
	logic rxPinSync;
	logic txPinSync;
	logic parityOn;
	logic oddParity;

	// odd-count of ones over the lower data bits of a character
	function automatic logic lowerOnes(input logic [8:0] c, input logic nine);
		lowerOnes = nine ? ^c[7:0] : ^c[6:0];
	endfunction

	function automatic logic topBit(input logic [8:0] c, input logic nine);
		topBit = nine ? c[8] : c[7];
	endfunction

	// pin synchronisers; stage one is read only by stage two
	assign pinRaw = {txPinIn, rxPinIn};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gSync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pinMeta_reg[g] <= 1'b1;
					pinSync_reg[g] <= 1'b1;
				end else if (ce) begin
					pinMeta_reg[g] <= pinRaw[g];
					pinSync_reg[g] <= pinMeta_reg[g];
				end
			end
		end
	endgenerate
	assign rxPinSync = pinSync_reg[0];
	assign txPinSync = pinSync_reg[1];

	// bus slave: one wait cycle, answer on the second edge
	assign request = read || write;
	assign accept = (bus_reg == BUS_ANSWER) && ce;
	assign waitrequest = request && !accept;
	assign doWrite = write && accept;
	assign lowLane = byteenable[0];
	assign wrHigh = doWrite && lowLane && (address == OFF_DIV_HIGH);
	assign wrLow = doWrite && lowLane && (address == OFF_DIV_LOW);
	assign wrFrameOne = doWrite && lowLane && (address == OFF_FRAME_ONE);
	assign wrFrameTwo = doWrite && lowLane && (address == OFF_FRAME_TWO);
	assign wrLine = doWrite && lowLane && (address == OFF_LINE_CTRL);
	assign readdata = readdata_reg;

	always_comb begin
		bus_next = bus_reg;
		case (bus_reg)
			BUS_IDLE: begin
				if (request) begin
					bus_next = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				bus_next = BUS_IDLE;
			end
			default: begin
				bus_next = BUS_IDLE;
			end
		endcase
	end

	// read mux; high byte reads the buffered value, unmapped reads zero
	always_comb begin
		readNext = 32'h0000_0000;
		if (address == OFF_DIV_HIGH) begin
			readNext[4:0] = highBuf_reg;
		end else if (address == OFF_DIV_LOW) begin
			readNext[7:0] = divisor_reg[7:0];
		end else if (address == OFF_FRAME_ONE) begin
			readNext[7:0] = frameOne_reg;
		end else if (address == OFF_FRAME_TWO) begin
			readNext[BIT_TX_EN] = txEnable_reg;
			readNext[BIT_RX_EN] = rxEnable_reg;
		end else if (address == OFF_LINE_CTRL) begin
			readNext[BIT_DIR] = wireDir_reg;
		end else if (address == OFF_STATUS) begin
			readNext[4:0] = {armed_reg, genEnable, txPinOe, rxPinOwned, rxSerial};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_reg <= BUS_IDLE;
			readdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			bus_reg <= bus_next;
			if (bus_reg == BUS_IDLE && read) begin
				readdata_reg <= readNext;
			end
		end
	end

	// divisor: high five bits only buffered until low byte written
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			highBuf_reg <= RST_DIV_HIGH;
			divisor_reg <= {RST_DIV_HIGH, RST_DIV_LOW};
		end else if (ce) begin
			if (wrHigh) begin
				highBuf_reg <= writedata[4:0];
			end
			if (wrLow) begin
				divisor_reg <= {highBuf_reg, writedata[7:0]};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameOne_reg <= RST_FRAME_ONE;
			txEnable_reg <= 1'b0;
			rxEnable_reg <= 1'b0;
			wireDir_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else if (ce) begin
			if (wrFrameOne) begin
				frameOne_reg <= writedata[7:0];
			end
			if (wrFrameTwo) begin
				txEnable_reg <= writedata[BIT_TX_EN];
				rxEnable_reg <= writedata[BIT_RX_EN];
				// sticky: generator stays armed once either side was enabled
				if (writedata[BIT_TX_EN] || writedata[BIT_RX_EN]) begin
					armed_reg <= 1'b1;
				end
			end
			if (wrLine) begin
				wireDir_reg <= writedata[BIT_DIR];
			end
		end
	end

	// configuration fields
	assign loopSel = frameOne_reg[BIT_LOOP];
	assign rxSource = frameOne_reg[BIT_RX_SOURCE];
	assign waitFreeze = frameOne_reg[BIT_WAIT_FREEZE];
	assign nineBitChars = frameOne_reg[BIT_NINE];
	assign addressMarkWake = frameOne_reg[BIT_WAKE];
	assign idleAfterStop = frameOne_reg[BIT_IDLE_TYPE];
	assign parityOn = frameOne_reg[BIT_PAR_EN];
	assign oddParity = frameOne_reg[BIT_PAR_TYPE];
	assign transmitterEnable = txEnable_reg && !stopMode;
	assign receiverEnable = rxEnable_reg && !stopMode;
	assign frameBits = nineBitChars ? FRAME_BITS_9 : FRAME_BITS_8;
	assign idleBits = nineBitChars ? IDLE_BITS_9 : IDLE_BITS_8;

	// parity lives in the top data bit; generator fills it, checker tests it
	assign txParityBit = parityOn ? (lowerOnes(txChar, nineBitChars) ^ oddParity)
		: topBit(txChar, nineBitChars);
	assign rxParityError = parityOn
		&& ((lowerOnes(rxChar, nineBitChars) ^ topBit(rxChar, nineBitChars)) != oddParity);

	// routing: receiver source only counts with loop select set
	assign route = !loopSel ? ROUTE_NORMAL : (rxSource ? ROUTE_SINGLE : ROUTE_LOOP);
	assign rxPinOwned = receiverEnable && (route == ROUTE_NORMAL);
	assign txPinOut = txSerial;

	always_comb begin
		case (route)
			ROUTE_NORMAL: begin
				rxSerial = rxPinSync;
				txPinOe = transmitterEnable || (txBusy && !stopMode);
			end
			ROUTE_LOOP: begin
				rxSerial = txSerial;
				txPinOe = transmitterEnable || (txBusy && !stopMode);
			end
			ROUTE_SINGLE: begin
				// direction bit picks driver; receiver hears txSerial when set, the synchronised transmit pin when clear
				txPinOe = transmitterEnable && wireDir_reg;
				rxSerial = wireDir_reg ? txSerial : txPinSync;
			end
			default: begin
				rxSerial = rxPinSync;
				txPinOe = 1'b0;
			end
		endcase
	end

	// rate generator: armed, not stopped; wait freeze holds the count
	assign genEnable = armed_reg && !stopMode;
	assign genHold = waitMode && waitFreeze;

	ubc_rate_gen #(.W(DIV_W)) uRate (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.enable(genEnable),
		.hold(genHold),
		.divisor(divisor_reg),
		.tick(baudTick)
	);

	property p_high_buffered;
		@(posedge clk) disable iff (rst) (wrHigh && !wrLow) |=> $stable(divisor_reg);
	endproperty
	a_high_buffered: assert property (p_high_buffered) else $error("high write moved divisor");

	property p_low_loads;
		@(posedge clk) disable iff (rst)
			wrLow |=> divisor_reg == {$past(highBuf_reg), $past(writedata[7:0])};
	endproperty
	a_low_loads: assert property (p_low_loads) else $error("low write did not load divisor");

	property p_unarmed_silent;
		@(posedge clk) disable iff (rst) !armed_reg |=> !baudTick;
	endproperty
	a_unarmed_silent: assert property (p_unarmed_silent) else $error("tick before enable");

	property p_stop_silent;
		@(posedge clk) disable iff (rst) (stopMode && ce) [*2] |-> !baudTick;
	endproperty
	a_stop_silent: assert property (p_stop_silent) else $error("tick in stop mode");

	property p_wait_freeze;
		@(posedge clk) disable iff (rst) (ce && waitMode && waitFreeze) |=> !baudTick;
	endproperty
	a_wait_freeze: assert property (p_wait_freeze) else $error("tick during wait freeze");

	property p_loopback;
		@(posedge clk) disable iff (rst)
			(loopSel && !rxSource) |-> (rxSerial == txSerial) && !rxPinOwned;
	endproperty
	a_loopback: assert property (p_loopback) else $error("loopback route wrong");

	property p_rx_release;
		@(posedge clk) disable iff (rst) (loopSel || !rxEnable_reg) |-> !rxPinOwned;
	endproperty
	a_rx_release: assert property (p_rx_release) else $error("receive pin held");

	property p_single_dir;
		@(posedge clk) disable iff (rst)
			(loopSel && rxSource && !wireDir_reg) |-> !txPinOe && (rxSerial == txPinSync);
	endproperty
	a_single_dir: assert property (p_single_dir) else $error("single-wire direction ignored");

	property p_parity_sum;
		@(posedge clk) disable iff (rst)
			(parityOn && !nineBitChars) |-> ((^txChar[6:0]) ^ txParityBit) == oddParity;
	endproperty
	a_parity_sum: assert property (p_parity_sum) else $error("parity bit wrong");

	property p_bus_answer;
		@(posedge clk) disable iff (rst) (request && ce && bus_reg == BUS_IDLE) |=> (ce |-> !waitrequest);
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

	c_write_pair: cover property (@(posedge clk) disable iff (rst) wrHigh ##[1:20] wrLow);
	c_single_wire: cover property (@(posedge clk) disable iff (rst) route == ROUTE_SINGLE && txPinOe);
	c_first_tick: cover property (@(posedge clk) disable iff (rst) $rose(armed_reg) ##[1:40] baudTick);
	c_nine_parity: cover property (@(posedge clk) disable iff (rst) nineBitChars && parityOn && rxParityError);
endmodule

// *** hw/ubc_pkg.sv ***
/*
 ubc_pkg: register map, field positions, reset values and frame counts
 for the serial baud and frame configuration block.
 assumes: 32-bit Avalon-MM word registers at byte addresses.
*/
package ubc_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int DIV_W = 13;
	localparam int DIV_HIGH_W = 5;
	localparam int ADDR_W = 5;

	localparam logic [4:0] OFF_DIV_HIGH = 5'h00;
	localparam logic [4:0] OFF_DIV_LOW = 5'h04;
	localparam logic [4:0] OFF_FRAME_ONE = 5'h08;
	localparam logic [4:0] OFF_FRAME_TWO = 5'h0C;
	localparam logic [4:0] OFF_LINE_CTRL = 5'h10;
	localparam logic [4:0] OFF_STATUS = 5'h14;

	localparam logic [4:0] RST_DIV_HIGH = 5'h00;
	localparam logic [7:0] RST_DIV_LOW = 8'h04;
	localparam logic [7:0] RST_FRAME_ONE = 8'h00;
	localparam logic [DIV_W-1:0] DIV_ZERO = 13'h0000;
	localparam logic [DIV_W-1:0] DIV_ONE = 13'h0001;

	localparam int BIT_LOOP = 7;
	localparam int BIT_WAIT_FREEZE = 6;
	localparam int BIT_RX_SOURCE = 5;
	localparam int BIT_NINE = 4;
	localparam int BIT_WAKE = 3;
	localparam int BIT_IDLE_TYPE = 2;
	localparam int BIT_PAR_EN = 1;
	localparam int BIT_PAR_TYPE = 0;
	localparam int BIT_TX_EN = 3;
	localparam int BIT_RX_EN = 2;
	localparam int BIT_DIR = 5;

	localparam logic [3:0] FRAME_BITS_8 = 4'hA;
	localparam logic [3:0] FRAME_BITS_9 = 4'hB;
	localparam logic [3:0] IDLE_BITS_8 = 4'hA;
	localparam logic [3:0] IDLE_BITS_9 = 4'hB;

	typedef enum logic [1:0] {
		ROUTE_NORMAL = 2'b00,
		ROUTE_LOOP = 2'b01,
		ROUTE_SINGLE = 2'b10
	} ubc_route_t;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} ubc_bus_t;
endpackage

// *** hw/ubc_rate_gen.sv ***
/*
 ubc_rate_gen: modulo divider giving one oversampling tick every
 divisor bus clocks, sixteen ticks per bit.
 assumes: divisor and control come from flops on the same clock.
*/
`timescale 1ns/1ps
module ubc_rate_gen import ubc_pkg::*; #(
	parameter int W = DIV_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic enable,
	input wire logic hold,
	input wire logic [W-1:0] divisor,
	output logic tick
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic tick_reg;
	logic active;
	logic wrap;

	// zero divisor keeps the counter parked, saving current
	assign active = enable && (divisor != '0);
	assign wrap = count_reg >= divisor;
	assign count_next = wrap ? W'(1) : W'(count_reg + W'(1));
	assign tick = tick_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= W'(1);
			tick_reg <= 1'b0;
		end else if (ce) begin
			if (!active) begin
				count_reg <= W'(1);
				tick_reg <= 1'b0;
			end else if (hold) begin
				tick_reg <= 1'b0; // frozen, count kept
			end else begin
				count_reg <= count_next;
				tick_reg <= wrap;
			end
		end
	end

	property p_zero_silent;
		@(posedge clk) disable iff (rst) (ce && divisor == '0) |=> !tick;
	endproperty
	a_zero_silent: assert property (p_zero_silent) else $error("tick with zero divisor");

	property p_tick_gap;
		@(posedge clk) disable iff (rst)
			(ce && tick && active && !hold && divisor > W'(1)) |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");

	property p_two_spacing;
		@(posedge clk) disable iff (rst)
			(tick && divisor == W'(2) && ce && active && !hold)
			##1 (ce && active && !hold && divisor == W'(2)) [*2] |-> tick;
	endproperty
	a_two_spacing: assert property (p_two_spacing) else $error("divide by two spacing wrong");

	c_tick: cover property (@(posedge clk) disable iff (rst) tick ##1 !tick ##1 tick);
endmodule

// *** test/tb_top.sv ***
/*
 tb_top: self-checking bench for the baud and frame configuration block.
 assumes: ce tied high, full byte enables, remote node on the pins.
*/
`timescale 1ns/1ps
module tb_top import ubc_pkg::*;;
	logic clk, rst, ce, read, write, stopMode, waitMode, txSerial, txBusy;
	logic sendLevel, drivesWire, waitrequest, rxPinIn, rxPinOwned, txPinIn;
	logic txPinOut, txPinOe, rxSerial, baudTick, transmitterEnable, receiverEnable;
	logic nineBitChars, addressMarkWake, idleAfterStop, txParityBit, rxParityError;
	logic [ADDR_W-1:0] address;
	logic [3:0] byteenable, frameBits, idleBits;
	logic [31:0] writedata, readdata, rd;
	logic [8:0] txChar, rxChar;
	logic [7:0] fc;
	int n_fail, comparisons, per, cnt, d;

	ubc_config i_ubc_config (.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .stopMode(stopMode), .waitMode(waitMode),
		.rxPinIn(rxPinIn), .rxPinOwned(rxPinOwned), .txPinIn(txPinIn), .txPinOut(txPinOut),
		.txPinOe(txPinOe), .txSerial(txSerial), .txBusy(txBusy), .rxSerial(rxSerial),
		.baudTick(baudTick), .transmitterEnable(transmitterEnable),
		.receiverEnable(receiverEnable), .nineBitChars(nineBitChars),
		.addressMarkWake(addressMarkWake), .idleAfterStop(idleAfterStop),
		.frameBits(frameBits), .idleBits(idleBits), .txChar(txChar),
		.txParityBit(txParityBit), .rxChar(rxChar), .rxParityError(rxParityError));
	ubc_remote_node i_ubc_remote_node (.txPinOut(txPinOut), .txPinOe(txPinOe),
		.sendLevel(sendLevel), .drivesWire(drivesWire), .rxLine(rxPinIn), .wireLevel(txPinIn));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task report_and_stop;
		$display("counts: comparisons %0d failures %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] v);
		int n;
		@(posedge clk);
		address <= a;
		writedata <= {24'h0, v};
		read <= !wr;
		write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			n_fail++;
			report_and_stop();
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// high byte first, then low, so the pair loads together
	task automatic setdiv(input int v);
		bus(1'b1, OFF_DIV_HIGH, 8'(v >> 8));
		bus(1'b1, OFF_DIV_LOW, 8'(v));
	endtask

	task automatic count_ticks(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge clk);
			if (baudTick === 1'b1) c++;
		end
	endtask

	task automatic period(output int p);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (baudTick !== 1'b1 && n < 9000);
		p = 0;
		do begin
			@(posedge clk);
			p++;
		end while (baudTick !== 1'b1 && p < 9000);
		if (baudTick !== 1'b1) begin
			n_fail++;
			report_and_stop();
		end
	endtask

	function automatic logic exp_par(input logic [7:0] f, input logic [8:0] c);
		logic top;
		top = f[4] ? c[8] : c[7];
		if (!f[1]) return top;
		return (f[4] ? ^c[7:0] : ^c[6:0]) ^ f[0];
	endfunction

	function automatic logic exp_err(input logic [7:0] f, input logic [8:0] c);
		return f[1] && ((f[4] ? ^c : ^c[7:0]) != f[0]);
	endfunction

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1; ce = 1'b1; read = 1'b0; write = 1'b0; address = '0; byteenable = 4'hF;
		writedata = '0; stopMode = 1'b0; waitMode = 1'b0; txSerial = 1'b1; txBusy = 1'b0;
		sendLevel = 1'b1; drivesWire = 1'b0; txChar = '0; rxChar = '0;
		n_fail = 0; comparisons = 0;
		void'($urandom(32'h4140));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, OFF_DIV_HIGH, 8'h00); chk("divHigh", 32'h0, rd);
		bus(1'b0, OFF_DIV_LOW, 8'h00); chk("divLow", {24'h0, RST_DIV_LOW}, rd);
		bus(1'b0, OFF_FRAME_ONE, 8'h00); chk("frameOne", 32'h0, rd);
		bus(1'b0, OFF_STATUS, 8'h00); chk("status", 32'h1, rd);
		count_ticks(60, cnt); chk("ticksUnarmed", 0, cnt);
		bus(1'b1, 5'h1C, 8'hFF);
		bus(1'b0, 5'h1C, 8'h00); chk("unmapped", 32'h0, rd);
		$display("test reset done");
		bus(1'b1, OFF_FRAME_TWO, 8'h08); period(per); chk("periodRst", 4, per);
		bus(1'b0, OFF_STATUS, 8'h00); chk("armed", 32'h1D, rd);
		bus(1'b1, OFF_DIV_LOW, 8'h03);
		bus(1'b1, OFF_DIV_HIGH, 8'hFF);
		bus(1'b0, OFF_DIV_HIGH, 8'h00); chk("highBuf", 32'h1F, rd);
		period(per); chk("highOnly", 3, per);
		setdiv(256); period(per); chk("div256", 256, per);
		setdiv(0); count_ticks(300, cnt); chk("divZero", 0, cnt);
		repeat (4) begin
			d = $urandom_range(60, 1);
			setdiv(d); period(per); chk("randDiv", d, per);
		end
		setdiv(1); period(per); chk("divOne", 1, per);
		$display("test divisor done");
		setdiv(3);
		stopMode <= 1'b1;
		// a tick launched on the edge that raised stop still stands one cycle
		@(posedge clk);
		count_ticks(30, cnt);
		chk("stopTicks", 0, cnt);
		chk("stopTxEn", 0, transmitterEnable);
		chk("stopOe", 0, txPinOe);
		stopMode <= 1'b0;
		period(per); chk("afterStop", 3, per);
		// freeze only counts while the wait bit is set
		bus(1'b1, OFF_FRAME_ONE, 8'h40);
		waitMode <= 1'b1;
		@(posedge clk);
		count_ticks(30, cnt);
		chk("waitFrozen", 0, cnt);
		bus(1'b1, OFF_FRAME_ONE, 8'h00);
		// thirty running edges hold exactly ten ticks whatever phase was held
		count_ticks(31, cnt);
		chk("waitRuns", 10, cnt);
		waitMode <= 1'b0;
		$display("test modes done");
		// transmitter off but still finishing a frame keeps the pin
		bus(1'b1, OFF_FRAME_TWO, 8'h00);
		txBusy <= 1'b1;
		count_ticks(1, cnt);
		chk("oeBusy", 1, txPinOe);
		txBusy <= 1'b0;
		count_ticks(1, cnt);
		chk("oeIdle", 0, txPinOe);
		bus(1'b1, OFF_FRAME_TWO, 8'h0C);
		sendLevel <= 1'b0;
		count_ticks(4, cnt); chk("rxNormal", 0, rxSerial);
		chk("ownedNormal", 1, rxPinOwned);
		chk("oeNormal", 1, txPinOe);
		chk("rxEn", 1, receiverEnable);
		stopMode <= 1'b1;
		count_ticks(1, cnt);
		chk("stopRxEn", 0, receiverEnable);
		chk("stopOwned", 0, rxPinOwned);
		stopMode <= 1'b0;
		bus(1'b1, OFF_FRAME_ONE, 8'h20);
		txSerial <= 1'b1;
		count_ticks(4, cnt); chk("rsrcIgnored", 0, rxSerial);
		bus(1'b1, OFF_FRAME_ONE, 8'h80);
		for (int i = 0; i < 2; i++) begin
			txSerial <= i[0];
			count_ticks(2, cnt); chk("rxLoop", i, rxSerial);
		end
		chk("ownedLoop", 0, rxPinOwned);
		bus(1'b1, OFF_FRAME_ONE, 8'hA0);
		bus(1'b1, OFF_LINE_CTRL, 8'h00);
		drivesWire <= 1'b1;
		count_ticks(4, cnt); chk("oeListen", 0, txPinOe);
		chk("rxWire0", 0, rxSerial);
		sendLevel <= 1'b1;
		count_ticks(4, cnt); chk("rxWire1", 1, rxSerial);
		drivesWire <= 1'b0;
		bus(1'b1, OFF_LINE_CTRL, 8'h20);
		txSerial <= 1'b0;
		count_ticks(2, cnt); chk("oeDrive", 1, txPinOe);
		chk("rxDrive", 0, rxSerial);
		chk("txPinOut", 0, txPinOut);
		$display("test routing done");
		for (int i = 0; i < 32; i++) begin
			fc = 8'(i);
			bus(1'b1, OFF_FRAME_ONE, fc);
			bus(1'b0, OFF_FRAME_ONE, 8'h00); chk("frameRead", {24'h0, fc}, rd);
			txChar <= 9'($urandom);
			rxChar <= 9'($urandom);
			count_ticks(2, cnt);
			chk("nine", fc[4], nineBitChars);
			chk("frameBits", fc[4] ? 11 : 10, frameBits);
			chk("idleBits", fc[4] ? 11 : 10, idleBits);
			chk("wake", fc[3], addressMarkWake);
			chk("idleType", fc[2], idleAfterStop);
			chk("txParity", exp_par(fc, txChar), txParityBit);
			chk("rxParity", exp_err(fc, rxChar), rxParityError);
		end
		$display("test frame done");
		report_and_stop();
	end
endmodule

// *** test/ubc_remote_node.sv ***
/*
 ubc_remote_node: far serial node facing the receive and transmit pins.
 assumes: both lines have pull-ups, so a released line reads high.
*/
`timescale 1ns/1ps
module ubc_remote_node (
	input wire logic txPinOut,
	input wire logic txPinOe,
	input wire logic sendLevel,
	input wire logic drivesWire,
	output logic rxLine,
	output logic wireLevel
);
	// own transmit line, held high between characters
	assign rxLine = sendLevel;
	// shared wire: block first, then remote, else the pull-up
	assign wireLevel = txPinOe ? txPinOut : (drivesWire ? sendLevel : 1'b1);
endmodule
